// [hdl/fcrs_pkg.sv]
// Constants, field positions, reset values and operation codes of the
// float/fixed conversion and reciprocal seed unit.
// Assumes a 40-bit register file word: sign, 8-bit exponent, 31-bit mantissa.
package fcrs_pkg;
    // Word widths of the register file and of the integer field.
    localparam int unsigned FCRS_DATA_W = 40;
    localparam int unsigned FCRS_INT_W = 32;
    // Register byte offsets on the APB side.
    localparam logic [7:0] FCRS_OFF_MODE = 8'h00;
    localparam logic [7:0] FCRS_OFF_ASTAT = 8'h04;
    localparam logic [7:0] FCRS_OFF_STKY = 8'h08;
    // Mode control field positions.
    localparam int unsigned FCRS_MODE_TRUNC = 0;
    localparam int unsigned FCRS_MODE_SAT = 1;
    // Arithmetic status field positions.
    localparam int unsigned FCRS_AF_ZERO = 0;
    localparam int unsigned FCRS_AF_NEG = 1;
    localparam int unsigned FCRS_AF_OVF = 2;
    localparam int unsigned FCRS_AF_CARRY = 3;
    localparam int unsigned FCRS_AF_INSIGN = 4;
    localparam int unsigned FCRS_AF_INV = 5;
    // Sticky status field positions.
    localparam int unsigned FCRS_SF_UNF = 0;
    localparam int unsigned FCRS_SF_OVF = 1;
    localparam int unsigned FCRS_SF_FOVF = 2;
    localparam int unsigned FCRS_SF_INV = 3;
    // Reset values.
    localparam logic [1:0] FCRS_MODE_RST = 2'h0;
    localparam logic [5:0] FCRS_ASTAT_RST = 6'h00;
    localparam logic [3:0] FCRS_STKY_RST = 4'h0;
    // Exponent codes and limits.
    localparam logic [7:0] FCRS_EXP_ALL = 8'hFF;
    localparam logic [7:0] FCRS_EXP_NMAX = 8'hFE;
    localparam logic [7:0] FCRS_BIAS = 8'h7F;
    localparam logic [7:0] FCRS_RCP_ELIM = 8'hFC;
    localparam logic [7:0] FCRS_RCP_ESUM = 8'hFD;
    localparam logic signed [33:0] FCRS_FIX_EMAX = 34'sh9D;
    localparam logic signed [33:0] FCRS_FIX_ELOST = 34'sh3F;
    localparam logic signed [33:0] FCRS_FIX_SHB = 34'sh9E;
    localparam logic signed [33:0] FCRS_FL_EMAX = 34'sh7F;
    localparam logic signed [33:0] FCRS_FL_EMIN = -34'sh7E;
    localparam logic signed [33:0] FCRS_BIAS_W = 34'sh7F;
    // Integer and special results.
    localparam logic [31:0] FCRS_INT_MAX = 32'h7FFF_FFFF;
    localparam logic [31:0] FCRS_INT_MIN = 32'h8000_0000;
    localparam logic [39:0] FCRS_ALL_ONES = 40'hFF_FFFF_FFFF;
    // Reciprocal table generator: entry = NUM / (BASE + 2i) - ONE, rounded.
    localparam int FCRS_RCP_NUM = 131072;
    localparam int FCRS_RCP_BASE = 257;
    localparam int FCRS_RCP_ONE = 256;
    // Operation codes issued by the sequencer.
    typedef enum logic [2:0] {
        FCRS_OP_FIX = 3'h0,
        FCRS_OP_CHOP = 3'h1,
        FCRS_OP_FLOAT = 3'h2,
        FCRS_OP_RECIP = 3'h3,
        FCRS_OP_EXPX = 3'h4
    } fcrs_op_t;
endpackage

// [hdl/fcrs_core.sv]
// Conversion unit: float to integer, integer to float, reciprocal seed and
// exponent extract, with status flags and an APB register slave.
// Assumes the sequencer drives operands from the same clock, one op a cycle.
//
// The register addresses and register access over APB were left to the implementer.

// Function
// - Float to integer gives 32-bit two's complement
// - Rounding convert: truncate-bit floors, else nearest
// - Chop convert always truncates toward zero
// - Scale operand adds to exponent first
// - Integer in upper 32 bits, extension field zeroed
// - Saturation clamps overflow to integer extremes
// - NaN, or unsaturated overflow, gives all ones
// - Underflow gives zero, floored negatives minus one
// - Convert flags: zero, negative; carry, sign cleared
// - Convert overflow flag: exponent above 157, infinity
// - Convert invalid flag: NaN or unsaturated overflow
// - Sticky underflow for fractional values; stickies follow
// - Integer to float is exact in the 40-bit word
// - Scaled float: overflow infinity/largest normal, underflow zero
// - Float flags: zero below -126, negative; carry, sign, invalid cleared
// - Float overflow flag above 127, only scaled
// - Scaled float updates stickies; unscaled leaves them
// - Seed mantissa from table by seven bits
// - Seed exponent minus e minus one, same sign
// - Seed: zero gives infinity, large gives zero
// - Seed flags and stickies follow seed results
// - Extract flags: zero, negative, overflow, invalid
// - Extract returns exponent minus 127, saturating specials
module fcrs_core #(
    parameter int unsigned DATA_W = fcrs_pkg::FCRS_DATA_W
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic op_valid,
    input wire fcrs_pkg::fcrs_op_t op_code,
    input wire logic [DATA_W-1:0] opnd_x,
    input wire logic [DATA_W-1:0] opnd_y,
    input wire logic scale_en,
    output logic res_valid_q,
    output logic [DATA_W-1:0] res_q,
    output logic [5:0] astat_q,
    output logic [3:0] sticky_q,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata_q,
    output logic pready,
    output logic pslverr
);
    // The datapath is written for the 40-bit word only.
    if (DATA_W != fcrs_pkg::FCRS_DATA_W) begin : g_chk
        $error("fcrs_core supports only a 40-bit data word");
    end
    // Operand fields of X; integers sit in the upper 32 bits.
    logic x_sign; // Sign of the float operand.
    logic [7:0] x_exp; // Biased exponent.
    logic [30:0] x_man; // Fraction below the hidden bit.
    logic [31:0] x_int; // Integer view of X.
    logic [31:0] y_int; // Integer view of the scale operand.
    logic x_nan; // Operand is not a number.
    logic x_inf; // Operand is an infinity.
    logic x_zero; // Zero or denormal, which is flushed to zero.
    logic signed [33:0] scl; // Scale, sign-extended, zero when absent.
    logic [1:0] mode_q; // Truncation and saturation control.
    logic trunc_m; // Truncation rounding selected.
    logic sat_m; // ALU saturation selected.
    fcrs_pkg::fcrs_op_t op_q; // Operation of the result now held.
    // Split the operands once for all datapaths.
    always_comb begin
        x_sign = opnd_x[39];
        x_exp = opnd_x[38:31];
        x_man = opnd_x[30:0];
        x_int = opnd_x[39:8];
        y_int = opnd_y[39:8];
        x_nan = (x_exp == fcrs_pkg::FCRS_EXP_ALL) && (x_man != 31'h0);
        x_inf = (x_exp == fcrs_pkg::FCRS_EXP_ALL) && (x_man == 31'h0);
        x_zero = (x_exp == 8'h00);
        scl = scale_en ? $signed({{2{y_int[31]}}, y_int}) : 34'sh0;
        trunc_m = mode_q[fcrs_pkg::FCRS_MODE_TRUNC];
        sat_m = mode_q[fcrs_pkg::FCRS_MODE_SAT];
    end
    // Float to integer; a 96-bit shifter keeps every fraction bit for shifts up to 64.
    logic signed [33:0] fx_ee; // Scaled biased exponent.
    logic fx_big; // Exponent beyond the integer range.
    logic fx_lost; // All mantissa bits fall below the last guard bit.
    logic [6:0] fx_sh; // Right shift of the 1.31 mantissa.
    logic [95:0] fx_wide; // Integer part from bit 64 up, fraction below.
    logic [31:0] fx_ip; // Integer part before rounding.
    logic fx_half; // First fraction bit.
    logic fx_rest; // Any fraction bit below the first.
    logic fx_inc; // Magnitude increment from rounding.
    logic [32:0] fx_mag; // Rounded magnitude.
    logic fx_movf; // Rounded magnitude does not fit.
    logic fx_ufl; // Nonzero value strictly inside (-1, 1).
    logic [31:0] fx_sint; // Signed integer result.
    logic [39:0] fx_res; // Word written back.
    logic [5:0] fx_af; // Status flags.
    always_comb begin
        fx_ee = $signed({26'h0, x_exp}) + scl;
        fx_big = fx_ee > fcrs_pkg::FCRS_FIX_EMAX;
        fx_lost = fx_ee < fcrs_pkg::FCRS_FIX_ELOST;
        fx_sh = 7'(fcrs_pkg::FCRS_FIX_SHB - fx_ee);
        fx_wide = {1'b1, x_man, 64'h0} >> fx_sh;
        fx_ip = fx_lost ? 32'h0 : fx_wide[95:64];
        fx_half = fx_lost ? 1'b0 : fx_wide[63];
        fx_rest = fx_lost ? 1'b1 : (fx_wide[62:0] != 63'h0);
        if (op_code == fcrs_pkg::FCRS_OP_CHOP) begin
            fx_inc = 1'b0;
        end else if (trunc_m) begin
            fx_inc = x_sign && (fx_half || fx_rest);
        end else begin
            fx_inc = fx_half && (fx_rest || fx_ip[0]);
        end
        fx_mag = {1'b0, fx_ip} + {32'h0, fx_inc};
        fx_movf = fx_mag[32] || (fx_mag[31] && !(x_sign && fx_mag[30:0] == 31'h0));
        fx_ufl = !x_zero && !x_nan && !x_inf && !fx_big && (fx_ip == 32'h0);
        // Two's complement of the magnitude.
        fx_sint = x_sign ? (~fx_mag[31:0] + 32'h1) : fx_mag[31:0];
        if (x_nan) begin
            fx_res = fcrs_pkg::FCRS_ALL_ONES;
        end else if (x_inf || fx_big || fx_movf) begin
            if (sat_m) begin
                fx_res = {x_sign ? fcrs_pkg::FCRS_INT_MIN : fcrs_pkg::FCRS_INT_MAX, 8'h00};
            end else begin
                fx_res = fcrs_pkg::FCRS_ALL_ONES;
            end
        end else if (x_zero) begin
            fx_res = 40'h00_0000_0000;
        end else if (fx_ufl) begin
            // Only the flooring convert sends negative fractions to -1.
            fx_res = (x_sign && trunc_m && op_code == fcrs_pkg::FCRS_OP_FIX) ?
                     {32'hFFFF_FFFF, 8'h00} : 40'h00_0000_0000;
        end else begin
            fx_res = {fx_sint, 8'h00};
        end
        fx_af = 6'h00; // Carry and input sign stay cleared.
        fx_af[fcrs_pkg::FCRS_AF_ZERO] = (fx_res[39:8] == 32'h0);
        fx_af[fcrs_pkg::FCRS_AF_NEG] = fx_res[39];
        fx_af[fcrs_pkg::FCRS_AF_OVF] = x_inf || (fx_big && !x_nan);
        fx_af[fcrs_pkg::FCRS_AF_INV] = x_nan || (!sat_m && (x_inf || fx_big || fx_movf));
    end
    // Most significant set bit of a nonzero magnitude.
    function automatic logic [4:0] fcrs_msb(input logic [31:0] v);
        logic [4:0] p;
        p = 5'h0;
        for (int i = 0; i < 32; i++) begin
            if (v[i]) begin
                p = 5'(i);
            end
        end
        return p;
    endfunction
    // Integer to float. A 32-bit integer has at most 31 bits below its
    // leading one, which the 31-bit mantissa holds, so the conversion is
    // exact and the rounding mode only picks the overflow answer.
    logic fl_neg; // Sign of the integer.
    logic [31:0] fl_mag; // Magnitude; -2^31 maps to 2^31.
    logic [4:0] fl_p; // Leading one position.
    logic [31:0] fl_norm; // Normalized magnitude, hidden bit at 31.
    logic signed [33:0] fl_ue; // Unbiased result exponent.
    logic fl_ovf; // Scaled exponent above the float range.
    logic fl_ufl; // Scaled exponent below the normal range.
    logic [39:0] fl_res; // Word written back.
    logic [5:0] fl_af; // Status flags.
    always_comb begin
        fl_neg = x_int[31];
        fl_mag = fl_neg ? (~x_int + 32'h1) : x_int;
        fl_p = fcrs_msb(fl_mag);
        fl_norm = fl_mag << (5'd31 - fl_p);
        fl_ue = $signed({29'h0, fl_p}) + scl;
        fl_ovf = scale_en && (fl_ue > fcrs_pkg::FCRS_FL_EMAX);
        fl_ufl = fl_ue < fcrs_pkg::FCRS_FL_EMIN;
        if (x_int == 32'h0) begin
            fl_res = 40'h00_0000_0000;
        end else if (fl_ovf) begin
            fl_res = trunc_m ? {fl_neg, fcrs_pkg::FCRS_EXP_NMAX, 31'h7FFF_FFFF} :
                               {fl_neg, fcrs_pkg::FCRS_EXP_ALL, 31'h0};
        end else if (fl_ufl) begin
            fl_res = {fl_neg, 39'h0};
        end else begin
            fl_res = {fl_neg, 8'(fl_ue + fcrs_pkg::FCRS_BIAS_W), fl_norm[30:0]};
        end
        fl_af = 6'h00; // Carry, input sign and invalid cleared.
        fl_af[fcrs_pkg::FCRS_AF_ZERO] = (x_int == 32'h0) || fl_ufl;
        fl_af[fcrs_pkg::FCRS_AF_NEG] = fl_res[39];
        fl_af[fcrs_pkg::FCRS_AF_OVF] = fl_ovf;
    end
    // Reciprocal seed table. Each entry is the rounded fraction of
    // 2/(1+(i+0.5)/128), the midpoint of its interval, which keeps the
    // relative error near 2^-8.
    logic [7:0] rcp_rom [128];
    for (genvar g = 0; g < 128; g++) begin : g_rom
        localparam int DIV = fcrs_pkg::FCRS_RCP_BASE + 2 * g;
        assign rcp_rom[g] = 8'((fcrs_pkg::FCRS_RCP_NUM + DIV / 2) / DIV
                               - fcrs_pkg::FCRS_RCP_ONE);
    end
    // Reciprocal seed and exponent extract.
    logic rc_big; // Operand exponent above +125, infinity included.
    logic [39:0] rc_res; // Seed word.
    logic [5:0] rc_af; // Seed flags.
    logic [39:0] ex_res; // Extract word.
    logic [5:0] ex_af; // Extract flags.
    always_comb begin
        rc_big = x_exp > fcrs_pkg::FCRS_RCP_ELIM;
        if (x_nan) begin
            rc_res = fcrs_pkg::FCRS_ALL_ONES;
        end else if (x_zero) begin
            rc_res = {x_sign, fcrs_pkg::FCRS_EXP_ALL, 31'h0};
        end else if (rc_big) begin
            rc_res = {x_sign, 39'h0};
        end else begin
            // Biased seed exponent 253 - exp is -e-1 rebiased.
            rc_res = {x_sign, fcrs_pkg::FCRS_RCP_ESUM - x_exp, rcp_rom[x_man[30:24]], 23'h0};
        end
        rc_af = 6'h00;
        rc_af[fcrs_pkg::FCRS_AF_ZERO] = rc_big && !x_nan;
        rc_af[fcrs_pkg::FCRS_AF_NEG] = x_sign;
        rc_af[fcrs_pkg::FCRS_AF_OVF] = x_zero;
        rc_af[fcrs_pkg::FCRS_AF_INV] = x_nan;
        if (x_nan) begin
            ex_res = fcrs_pkg::FCRS_ALL_ONES;
        end else if (x_inf) begin
            ex_res = sat_m ? {fcrs_pkg::FCRS_INT_MAX, 8'h00} :
                             {1'b0, fcrs_pkg::FCRS_EXP_ALL, 31'h0};
        end else if (x_zero) begin
            ex_res = sat_m ? {fcrs_pkg::FCRS_INT_MIN, 8'h00} :
                             {1'b1, fcrs_pkg::FCRS_EXP_ALL, 31'h0};
        end else begin
            ex_res = {32'($signed({1'b0, x_exp}) - $signed({1'b0, fcrs_pkg::FCRS_BIAS})), 8'h00};
        end
        ex_af = 6'h00;
        ex_af[fcrs_pkg::FCRS_AF_ZERO] = (ex_res[39:8] == 32'h0);
        ex_af[fcrs_pkg::FCRS_AF_NEG] = ex_res[39];
        ex_af[fcrs_pkg::FCRS_AF_OVF] = x_inf || x_zero;
        ex_af[fcrs_pkg::FCRS_AF_INV] = x_nan;
    end
    // Select the result of the issued operation and its sticky sets.
    logic res_ok; // A legal operation is issued this cycle.
    logic [39:0] nxt_res; // Word to write back.
    logic [5:0] nxt_af; // Flags to store.
    logic [3:0] sk_set; // Sticky bits to set.
    always_comb begin
        res_ok = op_valid;
        nxt_res = 40'h00_0000_0000;
        nxt_af = 6'h00;
        sk_set = 4'h0;
        unique case (op_code)
            fcrs_pkg::FCRS_OP_FIX, fcrs_pkg::FCRS_OP_CHOP: begin
                nxt_res = fx_res;
                nxt_af = fx_af;
                // Fixed overflow sticky is left alone.
                sk_set[fcrs_pkg::FCRS_SF_UNF] = fx_ufl;
                sk_set[fcrs_pkg::FCRS_SF_OVF] = fx_af[fcrs_pkg::FCRS_AF_OVF];
                sk_set[fcrs_pkg::FCRS_SF_INV] = fx_af[fcrs_pkg::FCRS_AF_INV];
            end
            fcrs_pkg::FCRS_OP_FLOAT: begin
                nxt_res = fl_res;
                nxt_af = fl_af;
                // Only the scaled form touches the stickies.
                sk_set[fcrs_pkg::FCRS_SF_UNF] = scale_en && fl_af[fcrs_pkg::FCRS_AF_ZERO];
                sk_set[fcrs_pkg::FCRS_SF_OVF] = fl_ovf;
            end
            fcrs_pkg::FCRS_OP_RECIP: begin
                nxt_res = rc_res;
                nxt_af = rc_af;
                sk_set[fcrs_pkg::FCRS_SF_UNF] = rc_af[fcrs_pkg::FCRS_AF_ZERO];
                sk_set[fcrs_pkg::FCRS_SF_OVF] = rc_af[fcrs_pkg::FCRS_AF_OVF];
                sk_set[fcrs_pkg::FCRS_SF_INV] = rc_af[fcrs_pkg::FCRS_AF_INV];
            end
            fcrs_pkg::FCRS_OP_EXPX: begin
                nxt_res = ex_res;
                nxt_af = ex_af;
                sk_set[fcrs_pkg::FCRS_SF_OVF] = ex_af[fcrs_pkg::FCRS_AF_OVF];
                sk_set[fcrs_pkg::FCRS_SF_INV] = ex_af[fcrs_pkg::FCRS_AF_INV];
            end
            default: begin
                // Unassigned codes produce nothing and change no state.
                res_ok = 1'b0;
            end
        endcase
    end
    // Result word, valid pulse and the operation behind them.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            res_valid_q <= 1'b0;
            res_q <= 40'h00_0000_0000;
            op_q <= fcrs_pkg::FCRS_OP_FIX;
        end else begin
            res_valid_q <= res_ok;
            if (res_ok) begin
                res_q <= nxt_res;
                op_q <= op_code;
            end
        end
    end
    // APB decode. The slave never waits; reads are captured in setup.
    logic apb_acc; // Access phase.
    logic hit_mode; // Mode control register selected.
    logic hit_astat; // Arithmetic status selected.
    logic hit_stky; // Sticky status selected.
    logic stky_wr; // Sticky clear write in access phase.
    logic [31:0] rd_mux; // Read data for the addressed register.
    always_comb begin
        apb_acc = psel && penable;
        hit_mode = (paddr == fcrs_pkg::FCRS_OFF_MODE);
        hit_astat = (paddr == fcrs_pkg::FCRS_OFF_ASTAT);
        hit_stky = (paddr == fcrs_pkg::FCRS_OFF_STKY);
        stky_wr = apb_acc && pwrite && hit_stky;
        rd_mux = 32'h0000_0000;
        if (hit_mode) begin
            rd_mux = {30'h0, mode_q};
        end else if (hit_astat) begin
            rd_mux = {26'h0, astat_q};
        end else if (hit_stky) begin
            rd_mux = {28'h0, sticky_q};
        end
    end
    assign pready = 1'b1;
    // Unmapped offsets answer with an error and read as zero.
    assign pslverr = apb_acc && !(hit_mode || hit_astat || hit_stky);
    // Reads are registered in setup; a flag raised then shows on the next read.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata_q <= rd_mux;
        end
    end
    // Mode control register, written by software.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            mode_q <= fcrs_pkg::FCRS_MODE_RST;
        end else if (apb_acc && pwrite && hit_mode) begin
            mode_q <= pwdata[1:0];
        end
    end
    // Arithmetic status follows the last operation; read only.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            astat_q <= fcrs_pkg::FCRS_ASTAT_RST;
        end else if (res_ok) begin
            astat_q <= nxt_af;
        end
    end
    // Sticky status: write one to clear, and a set in the same cycle wins.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            sticky_q <= fcrs_pkg::FCRS_STKY_RST;
        end else begin
            sticky_q <= (sticky_q & ~(stky_wr ? pwdata[3:0] : 4'h0))
                        | (res_ok ? sk_set : 4'h0);
        end
    end
    default clocking fcrs_cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);
    AST_FIX_ZEXT: assert property (op_valid && op_code == fcrs_pkg::FCRS_OP_CHOP
        && !x_nan && !x_inf && !fx_big |=> res_q[7:0] == 8'h00)
        else $error("chop result extension not zero");
    AST_NAN_ONES: assert property (op_valid && x_nan && op_code != fcrs_pkg::FCRS_OP_FLOAT
        && op_code inside {[fcrs_pkg::FCRS_OP_FIX:fcrs_pkg::FCRS_OP_EXPX]}
        |=> res_valid_q && res_q == fcrs_pkg::FCRS_ALL_ONES)
        else $error("NaN operand did not give all ones");
    AST_SAT_POS: assert property (op_valid && op_code == fcrs_pkg::FCRS_OP_FIX
        && sat_m && x_inf && !x_sign |=> res_q[39:8] == fcrs_pkg::FCRS_INT_MAX)
        else $error("saturated positive infinity wrong");
    AST_FIX_FLAGS: assert property (op_valid && op_code == fcrs_pkg::FCRS_OP_CHOP
        |=> astat_q[fcrs_pkg::FCRS_AF_ZERO] == (res_q[39:8] == 32'h0)
        && !astat_q[fcrs_pkg::FCRS_AF_CARRY] && !astat_q[fcrs_pkg::FCRS_AF_INSIGN])
        else $error("convert flags wrong");
    AST_RCP_EXP: assert property (op_valid && op_code == fcrs_pkg::FCRS_OP_RECIP
        && !x_zero && x_exp <= fcrs_pkg::FCRS_RCP_ELIM
        |=> res_q[38:31] == 8'(fcrs_pkg::FCRS_RCP_ESUM - $past(x_exp))
        && res_q[39] == $past(x_sign))
        else $error("seed exponent or sign wrong");
    AST_RCP_ZERO: assert property (op_valid && op_code == fcrs_pkg::FCRS_OP_RECIP
        && x_zero |=> res_q[38:0] == {fcrs_pkg::FCRS_EXP_ALL, 31'h0}
        && astat_q[fcrs_pkg::FCRS_AF_OVF] && sticky_q[fcrs_pkg::FCRS_SF_OVF])
        else $error("seed of zero wrong");
    AST_FL_NOOVF: assert property (op_valid && op_code == fcrs_pkg::FCRS_OP_FLOAT
        && !scale_en |=> !astat_q[fcrs_pkg::FCRS_AF_OVF] && !astat_q[fcrs_pkg::FCRS_AF_INV])
        else $error("unscaled float raised overflow");
    AST_STKY_HOLD: assert property (op_valid && op_code == fcrs_pkg::FCRS_OP_FLOAT
        && !scale_en && !stky_wr |=> sticky_q == $past(sticky_q))
        else $error("unscaled float changed stickies");
    AST_EXPX: assert property (op_valid && op_code == fcrs_pkg::FCRS_OP_EXPX
        && !x_zero && !x_inf && !x_nan
        |=> $signed(res_q[39:8]) == $signed({24'h0, $past(x_exp)}) - 32'sh7F)
        else $error("extracted exponent wrong");
endmodule

// [hdl/fcrs_core_end.sv]
// Holds no logic; the whole conversion unit lives in the core module.
// Assumes nothing of its surroundings.

// [testbench/fcrs_rf_model.sv]
// Register file model: takes each result word and its flags.
// Assumes the unit's result pulse is one cycle wide.
module fcrs_rf_model (
    input wire logic clk_sys,
    input wire logic res_valid_q,
    input wire logic [39:0] res_q,
    input wire logic [5:0] astat_q,
    output logic wr_en_q,
    output logic [45:0] wr_word_q
);
    timeunit 1ns;
    timeprecision 1ps;
    // One whole 46-bit word, six flags over the 40-bit result, is written back per pulse.
    always_ff @(posedge clk_sys) begin
        wr_en_q <= res_valid_q;
        wr_word_q <= {astat_q, res_q};
    end
endmodule

// [testbench/tb.sv]
// Self-checking bench for the conversion unit.
// Assumes one-cycle result latency and an APB slave that answers at once.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 0, reset_n = 0, op_valid = 0, scale_en = 0, res_valid_q, wr_en_q;
    logic psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    fcrs_pkg::fcrs_op_t op_code = fcrs_pkg::FCRS_OP_FIX;
    logic [39:0] opnd_x = '0, opnd_y = '0, res_q;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata_q;
    logic [5:0] astat_q;
    logic [3:0] sticky_q;
    logic [45:0] wr_word_q, exp_q[$];
    int err_total = 0, check_count = 0;
    always #5 clk_sys = ~clk_sys;
    fcrs_core u_fcrs_core (.clk_sys, .reset_n, .op_valid, .op_code, .opnd_x, .opnd_y,
        .scale_en, .res_valid_q, .res_q, .astat_q, .sticky_q, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata_q, .pready, .pslverr);
    fcrs_rf_model u_fcrs_rf_model (.clk_sys, .res_valid_q, .res_q, .astat_q, .wr_en_q,
        .wr_word_q);
    task automatic chk(input logic [45:0] got, input logic [45:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Register read: error response and read data together.
    task automatic chk_rd(input logic [32:0] got, input logic [32:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: read %h expected %h", $time, got, exp);
        end
    endtask
    // Issue one op and note the flags and word it should produce.
    task automatic op(input logic [2:0] c, input logic [39:0] x, y, input logic s,
            input logic [45:0] e);
        op_valid <= 1;
        op_code <= fcrs_pkg::fcrs_op_t'(c);
        opnd_x <= x;
        opnd_y <= y;
        scale_en <= s;
        exp_q.push_back(e);
        @(posedge clk_sys);
    endtask
    // One APB transfer; reads are checked with the error response.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
            input logic [32:0] e);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        if (!w) chk_rd({pslverr, prdata_q}, e);
        psel <= 0;
        penable <= 0;
        @(posedge clk_sys);
    endtask
    task automatic close_out;
        if (err_total == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // The oldest note is compared when the model takes a word.
    always @(negedge clk_sys) if (wr_en_q) chk(wr_word_q, exp_q.pop_front());
    initial begin
        logic [7:0] e;
        logic [31:0] v;
        void'($urandom(32'h6fff_1357));
        repeat (8) @(posedge clk_sys);
        reset_n <= 1;
        @(posedge clk_sys);
        op(0, 40'h3F_C000_0000, 40'h0, 0, 46'h0000_0000_0200);
        op(0, 40'h3F_0000_0000, 40'h0, 0, 46'h0100_0000_0000);
        op(1, 40'hBF_C000_0000, 40'h0, 0, 46'h02FF_FFFF_FF00);
        op(0, 40'h3F_8000_0000, 40'h3_00, 1, 46'h0000_0000_0800);
        op(0, 40'h7F_8000_0000, 40'h0, 0, 46'h26FF_FFFF_FFFF);
        op(0, 40'h7F_C000_0000, 40'h0, 0, 46'h22FF_FFFF_FFFF);
        op(2, 40'h00_0000_0100, 40'h0, 0, 46'h003F_8000_0000);
        op(2, 40'hFF_FFFF_FE00, 40'h0, 0, 46'h02C0_0000_0000);
        op(3, 40'h3F_8000_0000, 40'h0, 0, 46'h003F_7F00_0000);
        op(3, 40'h00_0000_0000, 40'h0, 0, 46'h047F_8000_0000);
        op(3, 40'h7E_8000_0000, 40'h0, 0, 46'h0100_0000_0000);
        op(2, 40'h00_0000_0100, 40'hC8_00, 1, 46'h047F_8000_0000);
        op(4, 40'h3F_0000_0000, 40'h0, 0, 46'h02FF_FFFF_FF00);
        op_valid <= 0;
        @(posedge clk_sys);
        apb(0, 8'h08, 32'h0, 33'h0_0000_000B);
        apb(0, 8'h04, 32'h0, 33'h0_0000_0002);
        apb(1, 8'h08, 32'h0000_000F, 33'h0);
        apb(1, 8'h00, 32'h0000_0003, 33'h0);
        op(0, 40'hBF_C000_0000, 40'h0, 0, 46'h02FF_FFFF_FE00);
        op(0, 40'hBF_0000_0000, 40'h0, 0, 46'h02FF_FFFF_FF00);
        op(0, 40'h7F_8000_0000, 40'h0, 0, 46'h047F_FFFF_FF00);
        op(4, 40'h00_0000_0000, 40'h0, 0, 46'h0680_0000_0000);
        op(2, 40'h00_0000_0100, 40'hC8_00, 1, 46'h047F_7FFF_FFFF);
        repeat (4) begin
            e = 8'($urandom_range(254, 1));
            v = 32'(e) - 32'd127;
            op(4, {1'b0, e, 31'($urandom)}, 40'h0, 0, {4'h0, v[31], v == 0, v, 8'h00});
        end
        op_valid <= 0;
        @(posedge clk_sys);
        apb(0, 8'h08, 32'h0, 33'h0_0000_0003);
        apb(0, 8'h10, 32'h0, 33'h1_0000_0000);
        apb(0, 8'h00, 32'h0, 33'h0_0000_0003);
        // Mid-run reset: every register must return to its reset value.
        reset_n <= 0;
        repeat (2) @(posedge clk_sys);
        reset_n <= 1;
        @(posedge clk_sys);
        apb(0, 8'h08, 32'h0, 33'h0);
        apb(0, 8'h04, 32'h0, 33'h0);
        apb(0, 8'h00, 32'h0, 33'h0);
        chk(46'(exp_q.size()), 46'h0);
        close_out();
    end
    // Cut a hang short well beyond the expected run.
    initial begin
        #20000;
        err_total++;
        close_out();
    end
endmodule
